// *** ppp_regs.svh ***
`ifndef PPP_REGS_SVH
`define PPP_REGS_SVH

// Core clock rate
`define PPP_CLK_MHZ      125

// Low time of the accept pulse, in microseconds and in cycles
`define PPP_ACK_US       1
`define PPP_ACK_CYC      (`PPP_ACK_US * `PPP_CLK_MHZ)

// Hardware initialisation time after the init input goes high again
`define PPP_INIT_US      2
`define PPP_INIT_CYC     (`PPP_INIT_US * `PPP_CLK_MHZ)

// Host-side least init pulse, kept for reference by the far side
`define PPP_INIT_MIN_US  50

// Timer width
`define PPP_CNT_W        12

// Extensibility request values
`define PPP_REQ_NIBBLE   8'h00
`define PPP_REQ_DEVID    8'h04

// Identification record: two length bytes then the text
`define PPP_ID_LEN       5'h12
`define PPP_ID_STR       {8'h00, 8'h12, "MFG:GEN;CLS:PRT;"}
`define PPP_ID_W         (8 * 18)

// Nibble bit positions on the reverse status lines
`define PPP_NIB_BUSY     3
`define PPP_NIB_REQ      2
`define PPP_NIB_FLAG     1
`define PPP_NIB_AVAIL    0

`endif

// *** ppp_pkg.sv ***
package ppp_pkg;

  typedef enum logic [3:0] {
    PPP_IDLE     = 4'b0000,
    PPP_PUSH     = 4'b0001,
    PPP_ACK      = 4'b0010,
    PPP_NEG      = 4'b0011,
    PPP_REV_IDLE = 4'b0100,
    PPP_REV_SET  = 4'b0101,
    PPP_REV_CLK  = 4'b0110,
    PPP_REV_NIB  = 4'b0111,
    PPP_REV_END  = 4'b1000
  } ppp_state_t;

endpackage

// *** ppp_buf2.sv ***
`timescale 1ns/1ps

module ppp_buf2 #(
  parameter int WIDTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  input  wire logic             i_flush,
  input  wire logic [WIDTH-1:0] i_in_data,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  output logic      [WIDTH-1:0] o_out_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready
);

  logic [WIDTH-1:0] mem_ff [0:1];
  logic [WIDTH-1:0] nxt_mem [0:1];
  logic             wr_ptr_ff;
  logic             nxt_wr_ptr;
  logic             rd_ptr_ff;
  logic             nxt_rd_ptr;
  logic [1:0]       count_ff;
  logic [1:0]       nxt_count;
  logic             push;
  logic             pop;

  assign o_in_ready  = (count_ff != 2'h2);
  assign o_out_valid = (count_ff != 2'h0);
  assign o_out_data  = mem_ff[rd_ptr_ff];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  always_comb
  begin
    nxt_mem[0] = mem_ff[0];
    nxt_mem[1] = mem_ff[1];
    nxt_wr_ptr = wr_ptr_ff;
    nxt_rd_ptr = rd_ptr_ff;
    nxt_count  = count_ff;
    if (i_flush)
    begin
      nxt_wr_ptr = 1'b0;
      nxt_rd_ptr = 1'b0;
      nxt_count  = 2'h0;
    end
    else
    begin
      if (push)
      begin
        nxt_mem[wr_ptr_ff] = i_in_data;
        nxt_wr_ptr         = ~wr_ptr_ff;
      end
      if (pop)
        nxt_rd_ptr = ~rd_ptr_ff;
      nxt_count = count_ff + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      mem_ff[0] <= '0;
      mem_ff[1] <= '0;
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      count_ff  <= 2'h0;
    end
    else
    begin
      mem_ff[0] <= nxt_mem[0];
      mem_ff[1] <= nxt_mem[1];
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff  <= nxt_count;
    end
  end

endmodule // ppp_buf2

// *** ppp_port.sv ***
// Operation
// R1: Forward channel takes eight-bit bytes
// R2: Strobe paces, busy and accept pulse throttle
// R3: Data captured on strobe falling edge
// R4: Line n carries bit n, high means one
// R5: Busy high whenever no byte can be taken
// R6: Busy high from strobe until handshake ends
// R7: Busy high while input buffer is full
// R8: Busy high during init input and initialisation
// R9: Busy high while error is signalled
// R10: Busy high while port not selected
// R11: Busy rises first, falls after status inactive
// R12: Error low on fatal, paper, jam, ink
// R13: Paper-empty high exactly during paper-out
// R14: Low accept pulse after each byte
// R15: Select output constantly high when powered
// R16: Init on falling edge or low level
// R17: Host holds init low 50 us minimum
// R18: Only requests 00h and 04h answered yes
// R19: Request 00h selects nibble reverse transfer
// R20: Request 04h returns identification by nibbles
// R21: Accepted identification request sends stored string
// R22: Busy, request, flag, available carry nibble bits
// R23: Host waits for accept and busy low
// R24: Strobe and init synchronised; autofeed, select-in ignored
`timescale 1ns/1ps
`include "ppp_regs.svh"

module ppp_port (
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_host_data_strobe_pulse_n,
  input  wire logic [7:0] i_host_data,
  input  wire logic       i_host_init_n,
  input  wire logic       i_host_autofeed_unused,
  input  wire logic       i_host_select_in_unused,
  input  wire logic       i_host_active,
  input  wire logic       i_host_busy,
  input  wire logic       i_port_selected,
  input  wire logic       i_err_fatal,
  input  wire logic       i_err_paper_out,
  input  wire logic       i_err_paper_jam,
  input  wire logic       i_err_ink_out,
  output logic            o_busy,
  output logic            o_byte_accept_pulse_n,
  output logic            o_error_n,
  output logic            o_paper_empty_flag,
  output logic            o_device_selected_flag,
  output logic            o_rev_clk,
  output logic            o_rev_busy_bit,
  output logic            o_rev_data_request,
  output logic            o_rev_flag,
  output logic            o_rev_data_available_n,
  output logic [7:0]      o_rx_data,
  output logic            o_rx_valid,
  input  wire logic       i_rx_ready,
  input  wire logic [7:0] i_tx_data,
  input  wire logic       i_tx_valid,
  output logic            o_tx_ready,
  output logic            o_init_busy
);

  localparam logic [`PPP_ID_W-1:0] ID_STR = `PPP_ID_STR;

  // Pin synchronisers: stage 0 feeds stage 1 only, stage 2 is history
  logic [2:0] stb_sync_ff;
  logic [2:0] init_sync_ff;
  logic [2:0] act_sync_ff;
  logic [2:0] hbusy_sync_ff;
  logic [7:0] data_s1_ff;
  logic [7:0] data_s2_ff;

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      stb_sync_ff   <= 3'h7;
      init_sync_ff  <= 3'h7;
      act_sync_ff   <= 3'h0;
      hbusy_sync_ff <= 3'h7;
      data_s1_ff    <= 8'h00;
      data_s2_ff    <= 8'h00;
    end
    else
    begin
      stb_sync_ff   <= {stb_sync_ff[1:0], i_host_data_strobe_pulse_n}; // R24
      init_sync_ff  <= {init_sync_ff[1:0], i_host_init_n}; // R24
      act_sync_ff   <= {act_sync_ff[1:0], i_host_active};
      hbusy_sync_ff <= {hbusy_sync_ff[1:0], i_host_busy};
      data_s1_ff    <= i_host_data; // R4
      data_s2_ff    <= data_s1_ff;
    end
  end

  logic stb_fall;
  logic act_rise;
  logic act_high;
  logic hbusy_fall;
  logic hbusy_rise;
  logic init_low;

  assign stb_fall   = stb_sync_ff[2] & ~stb_sync_ff[1]; // R3
  assign act_rise   = act_sync_ff[1] & ~act_sync_ff[2];
  assign act_high   = act_sync_ff[1];
  assign hbusy_fall = hbusy_sync_ff[2] & ~hbusy_sync_ff[1];
  assign hbusy_rise = hbusy_sync_ff[1] & ~hbusy_sync_ff[2];
  assign init_low   = ~init_sync_ff[1]; // R16

  // Initialisation timer, reloaded while init is low
  logic [`PPP_CNT_W-1:0] init_cnt_ff;
  logic [`PPP_CNT_W-1:0] nxt_init_cnt;
  logic                  init_busy;

  always_comb
  begin
    if (init_low)
      nxt_init_cnt = `PPP_CNT_W'(`PPP_INIT_CYC); // R16
    else if (init_cnt_ff != '0)
      nxt_init_cnt = init_cnt_ff - `PPP_CNT_W'(1);
    else
      nxt_init_cnt = init_cnt_ff;
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      init_cnt_ff <= `PPP_CNT_W'(`PPP_INIT_CYC);
    else
      init_cnt_ff <= nxt_init_cnt;
  end

  assign init_busy   = init_low | (init_cnt_ff != '0);
  assign o_init_busy = init_busy;

  // Receive buffer
  logic       buf_in_valid;
  logic       buf_in_ready;
  logic [7:0] byte_ff;
  logic [7:0] nxt_byte;

  ppp_buf2 #(
    .WIDTH (8)
  ) u_buf (
    .i_clk       (i_clk),
    .i_rst_b     (i_rst_b),
    .i_flush     (init_busy),
    .i_in_data   (byte_ff),
    .i_in_valid  (buf_in_valid),
    .o_in_ready  (buf_in_ready),
    .o_out_data  (o_rx_data),
    .o_out_valid (o_rx_valid),
    .i_out_ready (i_rx_ready)
  );

  // Link state machine
  ppp_pkg::ppp_state_t   state_ff;
  ppp_pkg::ppp_state_t   nxt_state;
  logic [`PPP_CNT_W-1:0] ack_cnt_ff;
  logic [`PPP_CNT_W-1:0] nxt_ack_cnt;
  logic [7:0]            req_ff;
  logic [7:0]            nxt_req;
  logic                  mode_id_ff;
  logic                  nxt_mode_id;
  logic [4:0]            id_idx_ff;
  logic [4:0]            nxt_id_idx;
  logic [7:0]            rev_byte_ff;
  logic [7:0]            nxt_rev_byte;
  logic                  nib_hi_ff;
  logic                  nxt_nib_hi;
  logic                  ack_n_ff;
  logic                  nxt_ack_n;
  logic                  flag_ff;
  logic                  nxt_flag;
  logic                  rev_clk_ff;
  logic                  nxt_rev_clk;
  logic [7:0]            id_byte;
  logic                  rev_have;
  logic [3:0]            nibble;

  assign id_byte  = ID_STR[8 * (`PPP_ID_W / 8 - 1 - 32'(id_idx_ff)) +: 8]; // R21
  assign rev_have = mode_id_ff ? (id_idx_ff < `PPP_ID_LEN) : i_tx_valid;
  assign nibble   = nib_hi_ff ? rev_byte_ff[7:4] : rev_byte_ff[3:0];

  always_comb
  begin
    nxt_state    = state_ff;
    nxt_ack_cnt  = ack_cnt_ff;
    nxt_req      = req_ff;
    nxt_mode_id  = mode_id_ff;
    nxt_id_idx   = id_idx_ff;
    nxt_rev_byte = rev_byte_ff;
    nxt_nib_hi   = nib_hi_ff;
    nxt_ack_n    = 1'b1;
    nxt_flag     = flag_ff;
    nxt_rev_clk  = rev_clk_ff;
    nxt_byte     = byte_ff;
    buf_in_valid = 1'b0;
    o_tx_ready   = 1'b0;
    if (init_busy)
    begin
      nxt_state   = ppp_pkg::PPP_IDLE; // R8
      nxt_flag    = 1'b0;
      nxt_rev_clk = 1'b1;
    end
    else if ((state_ff >= ppp_pkg::PPP_NEG) && !act_high)
    begin
      nxt_state   = ppp_pkg::PPP_IDLE;
      nxt_flag    = 1'b0;
      nxt_rev_clk = 1'b1;
    end
    else
    begin
      case (state_ff)
        ppp_pkg::PPP_IDLE:
        begin
          if (act_rise)
          begin
            nxt_req   = data_s2_ff;
            nxt_state = ppp_pkg::PPP_NEG;
          end
          else if (stb_fall && i_port_selected)
          begin
            nxt_byte  = data_s2_ff; // R1 R3
            nxt_state = ppp_pkg::PPP_PUSH;
          end
        end
        ppp_pkg::PPP_PUSH:
        begin
          buf_in_valid = 1'b1;
          if (buf_in_ready)
          begin
            nxt_ack_n   = 1'b0; // R14
            nxt_ack_cnt = `PPP_CNT_W'(`PPP_ACK_CYC - 1);
            nxt_state   = ppp_pkg::PPP_ACK;
          end
        end
        ppp_pkg::PPP_ACK:
        begin
          if (ack_cnt_ff != '0)
          begin
            nxt_ack_n   = 1'b0; // R2
            nxt_ack_cnt = ack_cnt_ff - `PPP_CNT_W'(1);
          end
          else
            nxt_state = ppp_pkg::PPP_IDLE;
        end
        ppp_pkg::PPP_NEG:
        begin
          nxt_id_idx = 5'h00;
          nxt_nib_hi = 1'b0;
          if (req_ff == `PPP_REQ_NIBBLE || req_ff == `PPP_REQ_DEVID) // R18
          begin
            nxt_flag    = 1'b1;
            nxt_mode_id = (req_ff == `PPP_REQ_DEVID); // R19 R20
            nxt_state   = ppp_pkg::PPP_REV_IDLE;
          end
          else
          begin
            nxt_flag  = 1'b0; // R18
            nxt_state = ppp_pkg::PPP_REV_END;
          end
        end
        ppp_pkg::PPP_REV_IDLE:
        begin
          if (rev_have && hbusy_fall)
          begin
            if (mode_id_ff)
              nxt_rev_byte = id_byte; // R21
            else
            begin
              nxt_rev_byte = i_tx_data;
              o_tx_ready   = 1'b1;
            end
            nxt_nib_hi = 1'b0;
            nxt_state  = ppp_pkg::PPP_REV_SET;
          end
        end
        ppp_pkg::PPP_REV_SET:
        begin
          nxt_rev_clk = 1'b0;
          nxt_state   = ppp_pkg::PPP_REV_CLK;
        end
        ppp_pkg::PPP_REV_CLK:
        begin
          if (hbusy_rise)
          begin
            nxt_rev_clk = 1'b1;
            if (nib_hi_ff)
            begin
              nxt_nib_hi = 1'b0;
              if (mode_id_ff)
                nxt_id_idx = id_idx_ff + 5'h01;
              nxt_state = ppp_pkg::PPP_REV_IDLE;
            end
            else
            begin
              nxt_nib_hi = 1'b1;
              nxt_state  = ppp_pkg::PPP_REV_NIB;
            end
          end
        end
        ppp_pkg::PPP_REV_NIB:
        begin
          if (hbusy_fall)
            nxt_state = ppp_pkg::PPP_REV_SET;
        end
        ppp_pkg::PPP_REV_END:
        begin
          nxt_state = ppp_pkg::PPP_REV_END;
        end
        default:
        begin
          nxt_state = ppp_pkg::PPP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_ff    <= ppp_pkg::PPP_IDLE;
      ack_cnt_ff  <= '0;
      req_ff      <= 8'h00;
      mode_id_ff  <= 1'b0;
      id_idx_ff   <= 5'h00;
      rev_byte_ff <= 8'h00;
      nib_hi_ff   <= 1'b0;
      ack_n_ff    <= 1'b1;
      flag_ff     <= 1'b0;
      rev_clk_ff  <= 1'b1;
      byte_ff     <= 8'h00;
    end
    else
    begin
      state_ff    <= nxt_state;
      ack_cnt_ff  <= nxt_ack_cnt;
      req_ff      <= nxt_req;
      mode_id_ff  <= nxt_mode_id;
      id_idx_ff   <= nxt_id_idx;
      rev_byte_ff <= nxt_rev_byte;
      nib_hi_ff   <= nxt_nib_hi;
      ack_n_ff    <= nxt_ack_n;
      flag_ff     <= nxt_flag;
      rev_clk_ff  <= nxt_rev_clk;
      byte_ff     <= nxt_byte;
    end
  end

  // Status outputs
  logic busy_ff;
  logic nxt_busy;
  logic err_n_ff;
  logic nxt_err_n;
  logic pe_ff;
  logic nxt_pe;
  logic err_any;
  logic in_nibble;
  logic rbusy_ff;
  logic nxt_rbusy;
  logic rreq_ff;
  logic nxt_rreq;
  logic rflag_ff;
  logic nxt_rflag;
  logic ravail_n_ff;
  logic nxt_ravail_n;

  assign err_any   = i_err_fatal | i_err_paper_out | i_err_paper_jam | i_err_ink_out; // R12
  assign in_nibble = (state_ff == ppp_pkg::PPP_REV_SET) || (state_ff == ppp_pkg::PPP_REV_CLK);

  always_comb
  begin
    nxt_busy = (state_ff != ppp_pkg::PPP_IDLE) // R5 R6
             | ~buf_in_ready // R7
             | init_busy // R8
             | err_any // R9
             | ~err_n_ff | pe_ff // R11
             | ~i_port_selected; // R10
    nxt_err_n    = ~(err_any & busy_ff); // R11 R12
    nxt_pe       = i_err_paper_out & busy_ff; // R11 R13
    nxt_rbusy    = in_nibble ? nibble[`PPP_NIB_BUSY] : 1'b1; // R22
    nxt_rreq     = in_nibble ? nibble[`PPP_NIB_REQ] : flag_ff; // R22
    nxt_rflag    = in_nibble ? nibble[`PPP_NIB_FLAG] : flag_ff; // R22
    nxt_ravail_n = in_nibble ? nibble[`PPP_NIB_AVAIL] : ~rev_have; // R22
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      busy_ff     <= 1'b1;
      err_n_ff    <= 1'b1;
      pe_ff       <= 1'b0;
      rbusy_ff    <= 1'b1;
      rreq_ff     <= 1'b0;
      rflag_ff    <= 1'b0;
      ravail_n_ff <= 1'b1;
    end
    else
    begin
      busy_ff     <= nxt_busy;
      err_n_ff    <= nxt_err_n;
      pe_ff       <= nxt_pe;
      rbusy_ff    <= nxt_rbusy;
      rreq_ff     <= nxt_rreq;
      rflag_ff    <= nxt_rflag;
      ravail_n_ff <= nxt_ravail_n;
    end
  end

  assign o_busy                 = busy_ff;
  assign o_byte_accept_pulse_n  = ack_n_ff;
  assign o_error_n              = err_n_ff;
  assign o_paper_empty_flag     = pe_ff;
  assign o_device_selected_flag = 1'b1; // R15
  assign o_rev_clk              = rev_clk_ff;
  assign o_rev_busy_bit         = rbusy_ff;
  assign o_rev_data_request     = rreq_ff;
  assign o_rev_flag             = rflag_ff;
  assign o_rev_data_available_n = ravail_n_ff;

endmodule // ppp_port

// *** ppp_port_monitor.sv ***
`timescale 1ns/1ps
module ppp_port_monitor (
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic i_port_selected,
  input  wire logic i_err_fatal,
  input  wire logic i_err_paper_out,
  input  wire logic i_err_paper_jam,
  input  wire logic i_err_ink_out,
  input  wire logic o_busy,
  input  wire logic o_byte_accept_pulse_n,
  input  wire logic o_error_n,
  input  wire logic o_paper_empty_flag,
  input  wire logic o_device_selected_flag,
  input  wire logic o_rx_valid,
  input  wire logic o_init_busy
);
  logic [7:0] ack_cnt_ff;
  logic [7:0] nxt_ack_cnt;
  logic       any_err;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  assign any_err = i_err_fatal | i_err_paper_out | i_err_paper_jam | i_err_ink_out;
  // Low time of the accept pulse
  always_comb nxt_ack_cnt = o_byte_accept_pulse_n ? 8'h00 : ack_cnt_ff + 8'h01;
  always_ff @(posedge i_clk or negedge i_rst_b)
    if (!i_rst_b)
      ack_cnt_ff <= 8'h00;
    else
      ack_cnt_ff <= nxt_ack_cnt;
  sel_high_a: assert property (o_device_selected_flag) else $error("select flag low");
  status_busy_a: assert property ((!o_error_n || o_paper_empty_flag) |-> o_busy) else $error("status without busy");
  busy_first_a: assert property (($fell(o_error_n) || $rose(o_paper_empty_flag)) |-> $past(o_busy))
    else $error("status before busy");
  err_set_a: assert property (any_err [*4] |-> !o_error_n) else $error("error not shown");
  err_clr_a: assert property (!any_err [*4] |-> o_error_n) else $error("error stuck");
  pe_set_a: assert property (i_err_paper_out [*4] |-> o_paper_empty_flag) else $error("paper flag missing");
  pe_clr_a: assert property (!i_err_paper_out [*4] |-> !o_paper_empty_flag) else $error("paper flag stuck");
  unsel_busy_a: assert property (!i_port_selected [*3] |-> o_busy) else $error("busy low unselected");
  init_busy_a: assert property (o_init_busy [*2] |-> o_busy) else $error("busy low in init");
  ack_busy_a: assert property (!o_byte_accept_pulse_n |-> o_busy) else $error("busy low in accept");
  ack_len_a: assert property ($rose(o_byte_accept_pulse_n) |-> ack_cnt_ff == 8'h7D) else $error("accept width");
  ack_data_a: assert property ($fell(o_byte_accept_pulse_n) |-> o_rx_valid) else $error("accept without byte");
endmodule // ppp_port_monitor

bind ppp_port ppp_port_monitor u_ppp_port_monitor (.i_clk, .i_rst_b, .i_port_selected, .i_err_fatal,
  .i_err_paper_out, .i_err_paper_jam, .i_err_ink_out, .o_busy, .o_byte_accept_pulse_n, .o_error_n,
  .o_paper_empty_flag, .o_device_selected_flag, .o_rx_valid, .o_init_busy);

// *** ppp_host_model.sv ***
`timescale 1ns/1ps
module ppp_host_model (
  input  wire logic       i_clk,
  input  wire logic       i_busy,
  input  wire logic       i_ack_n,
  input  wire logic       i_rev_clk,
  input  wire logic [3:0] i_nib,
  output logic            o_strobe_n,
  output logic [7:0]      o_data,
  output logic            o_init_n,
  output logic            o_active,
  output logic            o_host_busy
);
  initial {o_strobe_n, o_data, o_init_n, o_active, o_host_busy} = 12'h8_05;
  task automatic send(input logic [7:0] b, input bit wait_rdy);
    int i;
    for (i = 0; i < 3000 && wait_rdy && (i_busy || !i_ack_n); i++) @(negedge i_clk);
    o_data = b;
    repeat (4) @(negedge i_clk);
    o_strobe_n = 1'b0;
    repeat (4) @(negedge i_clk);
    o_strobe_n = 1'b1;
    repeat (3) @(negedge i_clk);
    // Hold time over: lines no longer show the byte
    o_data = ~b;
  endtask
  task automatic init_pulse;
    o_init_n = 1'b0;
    repeat (6250) @(negedge i_clk);
    o_init_n = 1'b1;
  endtask
  task automatic negotiate(input logic [7:0] req);
    o_data = req;
    repeat (4) @(negedge i_clk);
    o_active = 1'b1;
    repeat (8) @(negedge i_clk);
  endtask
  task automatic end_rev;
    o_active = 1'b0;
    o_data = ~o_data;
    repeat (8) @(negedge i_clk);
  endtask
  task automatic read_byte(output logic [7:0] b);
    int i;
    int k;
    for (k = 0; k < 2; k++)
    begin
      o_host_busy = 1'b0;
      for (i = 0; i < 50 && i_rev_clk; i++) @(negedge i_clk);
      b[k*4 +: 4] = i_nib;
      o_host_busy = 1'b1;
      for (i = 0; i < 50 && !i_rev_clk; i++) @(negedge i_clk);
    end
  endtask
endmodule // ppp_host_model

// *** tb_parallel_port_peripheral_side.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_parallel_port_peripheral_side;
  logic       clk, rst_b, strobe_n, init_n, active, host_busy, sel, rx_ready, tx_valid, afx, sli;
  logic       busy, ack_n, err_n, pe, dsel, rev_clk, rx_valid, tx_ready, init_busy;
  logic [7:0] data, rx_data, tx_data, got;
  logic [3:0] err, nib;
  logic [7:0] exp_q[$];
  logic [7:0] req_t[3] = '{8'h00, 8'h04, 8'h07};
  int         fail_count, checks, i, tx_taken;
  integer     seed = 90522;

  ppp_port u_ppp_port (.i_clk(clk), .i_rst_b(rst_b), .i_host_data_strobe_pulse_n(strobe_n), .i_host_data(data),
    .i_host_init_n(init_n), .i_host_autofeed_unused(afx), .i_host_select_in_unused(sli), .i_host_active(active),
    .i_host_busy(host_busy), .i_port_selected(sel), .i_err_fatal(err[0]), .i_err_paper_out(err[1]),
    .i_err_paper_jam(err[2]), .i_err_ink_out(err[3]), .o_busy(busy), .o_byte_accept_pulse_n(ack_n),
    .o_error_n(err_n), .o_paper_empty_flag(pe), .o_device_selected_flag(dsel), .o_rev_clk(rev_clk),
    .o_rev_busy_bit(nib[3]), .o_rev_data_request(nib[2]), .o_rev_flag(nib[1]), .o_rev_data_available_n(nib[0]),
    .o_rx_data(rx_data), .o_rx_valid(rx_valid), .i_rx_ready(rx_ready), .i_tx_data(tx_data),
    .i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .o_init_busy(init_busy));
  ppp_host_model u_ppp_host_model (.i_clk(clk), .i_busy(busy), .i_ack_n(ack_n), .i_rev_clk(rev_clk), .i_nib(nib),
    .o_strobe_n(strobe_n), .o_data(data), .o_init_n(init_n), .o_active(active), .o_host_busy(host_busy));

  always #4 clk = ~clk;

  // Reference stream: bytes leave in strobe order
  always @(posedge clk)
    if (rx_valid && rx_ready)
    begin
      `CHK(rx_data, exp_q.size() ? exp_q.pop_front() : 8'hxx)
    end

  // Reverse source bytes taken by the port
  always @(posedge clk)
    if (tx_ready)
      tx_taken++;

  task automatic tx_byte(input bit wait_rdy, input bit keep);
    logic [7:0] b;
    b = 8'($random(seed));
    {afx, sli} = 2'($random(seed));
    if (keep)
      exp_q.push_back(b);
    u_ppp_host_model.send(b, wait_rdy);
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    #200000;
    fail_count++;
    test_done;
  end

  initial
  begin
    {clk, rst_b, tx_valid, afx, sli, err, tx_data} = 17'h0_0000;
    sel = 1'b1;
    rx_ready = 1'b1;
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    for (i = 0; i < 400 && busy; i++) @(negedge clk);
    `CHK(busy, 1'b0)
    repeat (3) tx_byte(1, 1);
    repeat (300) @(negedge clk);
    `CHK(exp_q.size(), 0)
    `CHK(dsel, 1'b1)
    $display("test stream done");
    rx_ready = 1'b0;
    repeat (2) tx_byte(1, 1);
    repeat (300) @(negedge clk);
    `CHK({busy, rx_valid}, 2'b11)
    // Strobe in idle while full is held until room, not lost
    tx_byte(0, 1);
    rx_ready = 1'b1;
    repeat (300) @(negedge clk);
    `CHK({busy, rx_valid}, 2'b00)
    `CHK(exp_q.size(), 0)
    $display("test full buffer done");
    sel = 1'b0;
    repeat (5) @(negedge clk);
    `CHK(busy, 1'b1)
    tx_byte(0, 0);
    sel = 1'b1;
    repeat (300) @(negedge clk);
    `CHK({busy, rx_valid}, 2'b00)
    $display("test unselected done");
    for (i = 0; i < 4; i++)
    begin
      err = 4'h1 << i;
      repeat (6) @(negedge clk);
      `CHK({busy, err_n, pe}, {2'b10, i == 1})
      err = 4'h0;
      repeat (6) @(negedge clk);
      `CHK({busy, err_n, pe}, 3'b010)
    end
    $display("test errors done");
    rx_ready = 1'b0;
    tx_byte(1, 1);
    repeat (200) @(negedge clk);
    fork
      u_ppp_host_model.init_pulse();
      begin
        repeat (100) @(negedge clk);
        `CHK({busy, init_busy}, 2'b11)
      end
    join
    exp_q.delete();
    repeat (100) @(negedge clk);
    `CHK({busy, rx_valid}, 2'b10)
    repeat (300) @(negedge clk);
    `CHK(busy, 1'b0)
    rx_ready = 1'b1;
    $display("test init done");
    for (i = 0; i < 3; i++)
    begin
      tx_data = 8'($random(seed));
      tx_valid = (i == 0);
      u_ppp_host_model.negotiate(req_t[i]);
      `CHK(nib[2:1], {2{i < 2}})
      if (i < 2)
      begin
        `CHK(nib[0], 1'b0)
        u_ppp_host_model.read_byte(got);
        `CHK(got, i ? 8'h00 : tx_data)
        u_ppp_host_model.read_byte(got);
        `CHK(got, i ? 8'h12 : tx_data)
      end
      tx_valid = 1'b0;
      u_ppp_host_model.end_rev();
    end
    `CHK(tx_taken, 2)
    $display("test reverse done");
    test_done;
  end
endmodule // tb_parallel_port_peripheral_side
